// file: hw/nvmwu_pkg.sv
// Purpose: Shared constants for the nonvolatile write unlock block
// Assumes: 50 MHz mclk, byte-wide register port
// Notes: Register offsets are indexes on the plain register port
package nvmwu_pkg;
    localparam int CLK_PERIOD_NS = 20;
    // Register offsets
    localparam logic [2:0] CTRL_ONE_OFS = 3'h0;
    localparam logic [2:0] CTRL_TWO_OFS = 3'h1;
    localparam logic [2:0] PROG_KEY_OFS = 3'h2;
    localparam logic [2:0] DATA_KEY_OFS = 3'h3;
    localparam logic [2:0] STATUS_OFS = 3'h4;
    // Field positions
    localparam int FIX_TIME_BIT = 0;
    localparam int IRQ_EN_BIT = 1;
    localparam int OPT_WE_BIT = 7;
    localparam int WPA_BIT = 0;
    localparam int PROG_UNLOCK_BIT = 1;
    localparam int DONE_BIT = 2;
    localparam int DATA_UNLOCK_BIT = 3;
    localparam int HV_CLOSE_BIT = 6;
    localparam logic [7:0] CTRL_ONE_RST = 8'h00;
    localparam logic [7:0] CTRL_TWO_RST = 8'h00;
    // Unlock keys
    localparam logic [7:0] KEY_5X = 8'h56;
    localparam logic [7:0] KEY_AX = 8'hAE;
    localparam logic [7:0] ERASE_VALUE = 8'h00;
    // Memory map
    localparam logic [16:0] DATA_BASE = 17'h01000;
    localparam logic [16:0] DATA_LAST = 17'h017FF;
    localparam logic [16:0] OPT_BASE = 17'h04800;
    localparam logic [16:0] OPT_LAST = 17'h0487F;
    localparam logic [16:0] PROG_BASE = 17'h08000;
    localparam logic [16:0] PROG_LAST = 17'h17FFF;
    localparam int PAGE_SHIFT = 8;
    // Operation phase times
    localparam int ERASE_TIME_NS = 2000;
    localparam int WRITE_TIME_NS = 2000;
    localparam int HV_CLOSE_TIME_NS = 200;
    localparam logic [9:0] ERASE_CYCLES =
        10'((ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [9:0] WRITE_CYCLES =
        10'((WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [9:0] HV_CLOSE_CYCLES =
        10'((HV_CLOSE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    typedef enum logic [1:0] {
        KEY_IDLE = 2'h0,
        KEY_FIRST_OK = 2'h1,
        KEY_OPEN = 2'h3,
        KEY_LOCKED = 2'h2
    } nvmwu_key_state_type;

    typedef enum logic [1:0] {
        OP_IDLE = 2'h0,
        OP_ERASE = 2'h1,
        OP_WRITE = 2'h3,
        OP_HV_CLOSE = 2'h2
    } nvmwu_op_state_type;
endpackage

// file: hw/nvmwu_key_unlock.sv
// Purpose: Two-key unlock sequencer for one memory area
// Assumes: key_wr is a one-cycle pulse on mclk
// Notes: Key writes are compared, never stored
`timescale 1ns/100ps
module nvmwu_key_unlock #(
    parameter logic [7:0] KEY_FIRST = 8'h00,
    parameter logic [7:0] KEY_SECOND = 8'h00,
    parameter bit RETRY_FIRST = 1'b0
) (
    input wire logic mclk, // System clock
    input wire logic rst_n, // Async reset, active low
    input wire logic key_wr, // Write to key register
    input wire logic [7:0] key_data, // Written key
    input wire logic relock, // Software clears unlocked flag
    output logic unlocked // Area write-enabled
);
    nvmwu_pkg::nvmwu_key_state_type state_reg;
    nvmwu_pkg::nvmwu_key_state_type state_next;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            nvmwu_pkg::KEY_IDLE: begin
                if (key_wr && key_data == KEY_FIRST) begin
                    state_next = nvmwu_pkg::KEY_FIRST_OK;
                end else if (key_wr && !RETRY_FIRST) begin
                    state_next = nvmwu_pkg::KEY_LOCKED;
                end
            end
            nvmwu_pkg::KEY_FIRST_OK: begin
                if (key_wr && key_data == KEY_SECOND) begin
                    state_next = nvmwu_pkg::KEY_OPEN;
                end else if (key_wr) begin
                    state_next = nvmwu_pkg::KEY_LOCKED;
                end
            end
            nvmwu_pkg::KEY_OPEN: begin
                if (relock) begin
                    state_next = nvmwu_pkg::KEY_IDLE;
                end
            end
            default: begin
                state_next = nvmwu_pkg::KEY_LOCKED;
            end
        endcase
    end

    // Reset always lands protected
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= nvmwu_pkg::KEY_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    assign unlocked = (state_reg == nvmwu_pkg::KEY_OPEN);

    lock_open_key_a: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(unlocked) |-> $past(key_wr) && $past(key_data) == KEY_SECOND
            && $past(state_reg, 2) != nvmwu_pkg::KEY_LOCKED)
        else $error("area unlocked without correct second key");
    lockout_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
        state_reg == nvmwu_pkg::KEY_LOCKED |=> state_reg == nvmwu_pkg::KEY_LOCKED)
        else $error("key lockout left before reset");
    first_key_a: assert property (@(posedge mclk) disable iff (!rst_n)
        state_reg == nvmwu_pkg::KEY_IDLE && key_wr |=>
            (state_reg == nvmwu_pkg::KEY_FIRST_OK) == ($past(key_data) == KEY_FIRST))
        else $error("first key compare wrong");
endmodule

// file: hw/nvmwu_top.sv
// Purpose: Write unlock and byte program control for the NVM
// Assumes: Memory write port and register port on mclk
// Notes: Writes arriving while an operation runs are dropped
// Functional notes
// - Both areas write-protected after reset
// - User boot area never writable
// - First program key must be 0x56
// - Wrong first program key locks until reset
// - Wrong second program key 0xAE locks
// - Good second key unlocks; clearing relocks
// - First data key must be 0xAE
// - Wrong first data key allows retry
// - Wrong second data key 0x56 locks
// - Good second data key unlocks; clear relocks
// - Option writes need option write enable
// - Data writes concurrent; no data reads meanwhile (here data_read_block is raised only during program writes)
// - Byte write starts op; program stalls CPU
// - Data write stalls only in high-voltage-off
// - Writing 0x00 erases the byte
// - End-of-program flag set on completion
// - Protected write skipped, flags attempt
// - Flag set with enable raises interrupt
// - Erase word first only if not blank
// - Fixed-time bit forces erase every time
//
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
module nvmwu_top (
    input wire logic mclk, // 50 MHz system clock
    input wire logic rst_n, // Async reset, active low
    input wire logic [2:0] reg_addr, // Register offset
    input wire logic [7:0] reg_wdata, // Register write data
    input wire logic reg_wr, // Register write strobe
    input wire logic reg_rd, // Register read strobe
    output logic [7:0] reg_rdata, // Read data, cycle after strobe
    input wire logic [16:0] mem_addr, // CPU memory write address
    input wire logic [7:0] mem_wdata, // CPU memory write data
    input wire logic mem_wr, // CPU memory write strobe
    input wire logic word_blank, // Addressed word is erased
    input wire logic [7:0] user_boot_area, // Boot area size in pages
    output logic cpu_stall, // Hold processor
    output logic data_read_block, // Data area reads not allowed
    output logic nvm_busy, // Byte operation in progress
    output logic [16:0] nvm_addr, // Array target address
    output logic [7:0] nvm_data, // Array write byte
    output logic nvm_erase_en, // Array word erase phase
    output logic nvm_write_en, // Array byte write phase
    output logic high_voltage_off_flag, // Closing high-voltage phase
    output logic mem_irq // Memory interrupt, active high
);
    logic [7:0] control_reg_one;
    logic [7:0] control_reg_two;
    logic end_of_program_flag;
    logic protected_write_attempt_flag;
    logic program_unlocked_flag;
    logic data_unlocked_flag;
    logic [7:0] rdata_reg;
    logic prog_key_wr;
    logic data_key_wr;
    logic status_wr;
    logic status_rd;
    logic prog_relock;
    logic data_relock;
    logic in_prog;
    logic in_data;
    logic in_opt;
    logic in_boot;
    logic [16:0] prog_ofs;
    logic permitted;
    logic op_start;
    logic op_reject;
    logic op_done;
    logic need_erase;
    nvmwu_pkg::nvmwu_op_state_type op_state_reg;
    nvmwu_pkg::nvmwu_op_state_type op_state_next;
    logic [9:0] op_count_reg;
    logic [9:0] op_count_next;
    logic op_prog_area_reg;
    logic op_erase_only_reg;
    logic [16:0] nvm_addr_reg;
    logic [7:0] nvm_data_reg;

    assign prog_key_wr = reg_wr && reg_addr == nvmwu_pkg::PROG_KEY_OFS;
    assign data_key_wr = reg_wr && reg_addr == nvmwu_pkg::DATA_KEY_OFS;
    assign status_wr = reg_wr && reg_addr == nvmwu_pkg::STATUS_OFS;
    assign status_rd = reg_rd && reg_addr == nvmwu_pkg::STATUS_OFS;
    assign prog_relock = status_wr && !reg_wdata[nvmwu_pkg::PROG_UNLOCK_BIT];
    assign data_relock = status_wr && !reg_wdata[nvmwu_pkg::DATA_UNLOCK_BIT];

    nvmwu_key_unlock #(
        .KEY_FIRST(nvmwu_pkg::KEY_5X),
        .KEY_SECOND(nvmwu_pkg::KEY_AX),
        .RETRY_FIRST(1'b0)
    ) prog_unlock (
        .mclk(mclk),
        .rst_n(rst_n),
        .key_wr(prog_key_wr),
        .key_data(reg_wdata),
        .relock(prog_relock),
        .unlocked(program_unlocked_flag)
    );

    // Data area tolerates a bad first key
    nvmwu_key_unlock #(
        .KEY_FIRST(nvmwu_pkg::KEY_AX),
        .KEY_SECOND(nvmwu_pkg::KEY_5X),
        .RETRY_FIRST(1'b1)
    ) data_unlock (
        .mclk(mclk),
        .rst_n(rst_n),
        .key_wr(data_key_wr),
        .key_data(reg_wdata),
        .relock(data_relock),
        .unlocked(data_unlocked_flag)
    );

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            control_reg_one <= nvmwu_pkg::CTRL_ONE_RST;
        end else if (reg_wr && reg_addr == nvmwu_pkg::CTRL_ONE_OFS) begin
            control_reg_one <= reg_wdata;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            control_reg_two <= nvmwu_pkg::CTRL_TWO_RST;
        end else if (reg_wr && reg_addr == nvmwu_pkg::CTRL_TWO_OFS) begin
            control_reg_two <= reg_wdata;
        end
    end

    // Key registers read as zero since keys are never latched
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg <= 8'h00;
        end else if (reg_rd) begin
            if (reg_addr == nvmwu_pkg::CTRL_ONE_OFS) begin
                rdata_reg <= control_reg_one;
            end else if (reg_addr == nvmwu_pkg::CTRL_TWO_OFS) begin
                rdata_reg <= control_reg_two;
            end else if (reg_addr == nvmwu_pkg::STATUS_OFS) begin
                rdata_reg <= 8'h00;
                rdata_reg[nvmwu_pkg::WPA_BIT] <= protected_write_attempt_flag;
                rdata_reg[nvmwu_pkg::PROG_UNLOCK_BIT] <= program_unlocked_flag;
                rdata_reg[nvmwu_pkg::DONE_BIT] <= end_of_program_flag;
                rdata_reg[nvmwu_pkg::DATA_UNLOCK_BIT] <= data_unlocked_flag;
                rdata_reg[nvmwu_pkg::HV_CLOSE_BIT] <= high_voltage_off_flag;
            end else begin
                rdata_reg <= 8'h00;
            end
        end else begin
            rdata_reg <= 8'h00;
        end
    end

    assign reg_rdata = rdata_reg;

    // Address classification of the CPU write
    assign in_prog = mem_addr >= nvmwu_pkg::PROG_BASE && mem_addr <= nvmwu_pkg::PROG_LAST;
    assign in_data = mem_addr >= nvmwu_pkg::DATA_BASE && mem_addr <= nvmwu_pkg::DATA_LAST;
    assign in_opt = mem_addr >= nvmwu_pkg::OPT_BASE && mem_addr <= nvmwu_pkg::OPT_LAST;
    assign prog_ofs = mem_addr - nvmwu_pkg::PROG_BASE;
    assign in_boot = in_prog
        && prog_ofs[16:nvmwu_pkg::PAGE_SHIFT] < {1'b0, user_boot_area};

    // Boot pages stay shut whatever the keys did
    always_comb begin
        permitted = 1'b0;
        if (in_prog) begin
            permitted = program_unlocked_flag && !in_boot;
        end else if (in_data) begin
            permitted = data_unlocked_flag;
        end else if (in_opt) begin
            permitted = control_reg_two[nvmwu_pkg::OPT_WE_BIT];
        end
    end

    assign op_start = mem_wr && op_state_reg == nvmwu_pkg::OP_IDLE && permitted;
    assign op_reject = mem_wr && op_state_reg == nvmwu_pkg::OP_IDLE
        && (in_prog || in_data || in_opt) && !permitted;
    assign need_erase = control_reg_one[nvmwu_pkg::FIX_TIME_BIT]
        || !word_blank || mem_wdata == nvmwu_pkg::ERASE_VALUE;
    assign op_done = op_state_reg == nvmwu_pkg::OP_HV_CLOSE && op_count_reg == 10'h000;

    always_comb begin
        op_state_next = op_state_reg;
        op_count_next = op_count_reg;
        case (op_state_reg)
            nvmwu_pkg::OP_IDLE: begin
                if (op_start && need_erase) begin
                    op_state_next = nvmwu_pkg::OP_ERASE;
                    op_count_next = nvmwu_pkg::ERASE_CYCLES - 10'h001;
                end else if (op_start) begin
                    op_state_next = nvmwu_pkg::OP_WRITE;
                    op_count_next = nvmwu_pkg::WRITE_CYCLES - 10'h001;
                end
            end
            nvmwu_pkg::OP_ERASE: begin
                if (op_count_reg != 10'h000) begin
                    op_count_next = op_count_reg - 10'h001;
                end else if (op_erase_only_reg) begin
                    op_state_next = nvmwu_pkg::OP_HV_CLOSE;
                    op_count_next = nvmwu_pkg::HV_CLOSE_CYCLES - 10'h001;
                end else begin
                    op_state_next = nvmwu_pkg::OP_WRITE;
                    op_count_next = nvmwu_pkg::WRITE_CYCLES - 10'h001;
                end
            end
            nvmwu_pkg::OP_WRITE: begin
                if (op_count_reg != 10'h000) begin
                    op_count_next = op_count_reg - 10'h001;
                end else begin
                    op_state_next = nvmwu_pkg::OP_HV_CLOSE;
                    op_count_next = nvmwu_pkg::HV_CLOSE_CYCLES - 10'h001;
                end
            end
            default: begin
                if (op_count_reg != 10'h000) begin
                    op_count_next = op_count_reg - 10'h001;
                end else begin
                    op_state_next = nvmwu_pkg::OP_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            op_state_reg <= nvmwu_pkg::OP_IDLE;
            op_count_reg <= 10'h000;
        end else begin
            op_state_reg <= op_state_next;
            op_count_reg <= op_count_next;
        end
    end

    // Target latched once so a later CPU write cannot retarget the op
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            nvm_addr_reg <= 17'h00000;
            nvm_data_reg <= 8'h00;
            op_prog_area_reg <= 1'b0;
            op_erase_only_reg <= 1'b0;
        end else if (op_start) begin
            nvm_addr_reg <= mem_addr;
            nvm_data_reg <= mem_wdata;
            op_prog_area_reg <= in_prog;
            op_erase_only_reg <= mem_wdata == nvmwu_pkg::ERASE_VALUE;
        end
    end

    // Set wins over the clear-on-read
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            end_of_program_flag <= 1'b0;
        end else if (op_done) begin
            end_of_program_flag <= 1'b1;
        end else if (status_rd) begin
            end_of_program_flag <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            protected_write_attempt_flag <= 1'b0;
        end else if (op_reject) begin
            protected_write_attempt_flag <= 1'b1;
        end else if (status_rd) begin
            protected_write_attempt_flag <= 1'b0;
        end
    end

    // Level interrupt follows the sticky flags
    assign mem_irq = control_reg_one[nvmwu_pkg::IRQ_EN_BIT]
        && (end_of_program_flag || protected_write_attempt_flag);

    assign nvm_busy = op_state_reg != nvmwu_pkg::OP_IDLE;
    assign high_voltage_off_flag = op_state_reg == nvmwu_pkg::OP_HV_CLOSE;
    assign cpu_stall = (nvm_busy && op_prog_area_reg)
        || high_voltage_off_flag;
    assign data_read_block = nvm_busy && op_prog_area_reg;
    assign nvm_erase_en = op_state_reg == nvmwu_pkg::OP_ERASE;
    assign nvm_write_en = op_state_reg == nvmwu_pkg::OP_WRITE;
    assign nvm_addr = nvm_addr_reg;
    assign nvm_data = nvm_data_reg;

    reject_no_op_a: assert property (@(posedge mclk) disable iff (!rst_n)
        op_reject |=> protected_write_attempt_flag && !nvm_busy)
        else $error("protected write not refused");
    boot_shut_a: assert property (@(posedge mclk) disable iff (!rst_n)
        mem_wr && in_boot |-> !op_start)
        else $error("boot area write started");
    opt_gate_a: assert property (@(posedge mclk) disable iff (!rst_n)
        op_start && in_opt |-> control_reg_two[nvmwu_pkg::OPT_WE_BIT])
        else $error("option write without enable");
    prog_stall_a: assert property (@(posedge mclk) disable iff (!rst_n)
        op_start && in_prog |=> cpu_stall throughout nvm_busy [*2])
        else $error("processor not stalled for program write");
    data_no_stall_a: assert property (@(posedge mclk) disable iff (!rst_n)
        nvm_busy && !op_prog_area_reg |-> cpu_stall == high_voltage_off_flag)
        else $error("data write stall outside closing phase");
    eop_after_op_a: assert property (@(posedge mclk) disable iff (!rst_n)
        op_done |=> end_of_program_flag && !nvm_busy)
        else $error("completion flag missing");
    irq_raise_a: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(end_of_program_flag) && control_reg_one[nvmwu_pkg::IRQ_EN_BIT] |-> mem_irq)
        else $error("interrupt not raised");
    fixed_erase_a: assert property (@(posedge mclk) disable iff (!rst_n)
        op_start && control_reg_one[nvmwu_pkg::FIX_TIME_BIT] |=> nvm_erase_en)
        else $error("fixed time write skipped erase");
    blank_skip_a: assert property (@(posedge mclk) disable iff (!rst_n)
        op_start && !need_erase |=> nvm_write_en)
        else $error("blank word write did not skip erase");
    erase_only_a: assert property (@(posedge mclk) disable iff (!rst_n)
        nvm_erase_en && op_erase_only_reg && op_count_reg == 10'h000
            |=> high_voltage_off_flag)
        else $error("byte erase went on to write");
    // Gating by key state and area; the stall split depends on the target
    locked_prog_a: assert property (@(posedge mclk) disable iff (!rst_n)
        mem_wr && in_prog && !program_unlocked_flag |-> !op_start)
        else $error("locked program area write started");
    locked_data_a: assert property (@(posedge mclk) disable iff (!rst_n)
        mem_wr && in_data && !data_unlocked_flag |-> !op_start)
        else $error("locked data area write started");
    relock_prog_a: assert property (@(posedge mclk) disable iff (!rst_n)
        prog_relock |=> !program_unlocked_flag)
        else $error("program area not relocked");
    relock_data_a: assert property (@(posedge mclk) disable iff (!rst_n)
        data_relock |=> !data_unlocked_flag)
        else $error("data area not relocked");
    prog_read_block_a: assert property (@(posedge mclk) disable iff (!rst_n)
        op_start && in_prog |=> data_read_block)
        else $error("data reads allowed during program write");
    data_concurrent_a: assert property (@(posedge mclk) disable iff (!rst_n)
        op_start && in_data |=> !data_read_block && !cpu_stall)
        else $error("data write held the processor");
    attempt_irq_a: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(protected_write_attempt_flag) && control_reg_one[nvmwu_pkg::IRQ_EN_BIT] |-> mem_irq)
        else $error("interrupt not raised on refused write");
    dirty_erase_a: assert property (@(posedge mclk) disable iff (!rst_n)
        op_start && !word_blank |=> nvm_erase_en)
        else $error("non-blank word not erased first");
    write_close_a: assert property (@(posedge mclk) disable iff (!rst_n)
        nvm_write_en && op_count_reg == 10'h000 |=> high_voltage_off_flag)
        else $error("write phase did not close with high voltage off");
endmodule

// file: tb/nvmwu_top_test.sv
// Purpose: Self-checking bench for the write unlock and byte program block
// Assumes: Register port answers one cycle after a read strobe; 50 MHz mclk
// Notes: Each scenario starts from its own reset so lockouts never leak between them
`timescale 1ns/100ps
module nvmwu_top_test;
    localparam logic [7:0] ST_WPA = 8'h01 << nvmwu_pkg::WPA_BIT;
    localparam logic [7:0] ST_PROG = 8'h01 << nvmwu_pkg::PROG_UNLOCK_BIT;
    localparam logic [7:0] ST_DONE = 8'h01 << nvmwu_pkg::DONE_BIT;
    localparam logic [7:0] ST_DATA = 8'h01 << nvmwu_pkg::DATA_UNLOCK_BIT;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic [16:0] mem_addr = 17'h00000;
    logic [7:0] mem_wdata = 8'h00;
    logic mem_wr = 1'b0;
    logic word_blank = 1'b0;
    logic [7:0] user_boot_area = 8'h02;
    logic cpu_stall, data_read_block, nvm_busy, nvm_erase_en, nvm_write_en;
    logic [16:0] nvm_addr;
    logic [7:0] nvm_data;
    logic high_voltage_off_flag, mem_irq;
    int bad_count = 0;
    int n_tests = 0;

    always #10 mclk = ~mclk;

    nvmwu_top dut_u (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_wr(mem_wr), .word_blank(word_blank),
        .user_boot_area(user_boot_area), .cpu_stall(cpu_stall),
        .data_read_block(data_read_block), .nvm_busy(nvm_busy), .nvm_addr(nvm_addr),
        .nvm_data(nvm_data), .nvm_erase_en(nvm_erase_en), .nvm_write_en(nvm_write_en),
        .high_voltage_off_flag(high_voltage_off_flag), .mem_irq(mem_irq));

    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check(input logic [16:0] seen, input logic [16:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
    endtask

    task automatic reg_write(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [2:0] a, output logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task automatic status_is(input logic [7:0] exp);
        logic [7:0] d;
        reg_read(nvmwu_pkg::STATUS_OFS, d);
        check(17'(d), 17'(exp));
    endtask

    task automatic keys(input logic [2:0] a, input logic [7:0] k1, input logic [7:0] k2);
        reg_write(a, k1);
        reg_write(a, k2);
    endtask

    task automatic mem_write(input logic [16:0] a, input logic [7:0] d, input logic blank);
        @(posedge mclk);
        mem_addr <= a;
        mem_wdata <= d;
        word_blank <= blank;
        mem_wr <= 1'b1;
        @(posedge mclk);
        mem_wr <= 1'b0;
    endtask

    // One byte operation, phase lengths and stall behaviour judged per cycle
    task automatic run_op(input logic [16:0] a, input logic [7:0] d, input logic blank,
        input logic prog, input logic er, input logic wr, input logic [7:0] st, input logic irq);
        int ne, nw, nh, sbad, k;
        ne = 0;
        nw = 0;
        nh = 0;
        sbad = 0;
        mem_write(a, d, blank);
        #1;
        check(17'(nvm_busy), 17'h1);
        check(nvm_addr, a);
        check(17'(nvm_data), 17'(d));
        for (k = 0; k < 400 && nvm_busy === 1'b1; k++) begin
            if (nvm_erase_en === 1'b1 && nw > 0) sbad++;
            ne += int'(nvm_erase_en === 1'b1);
            nw += int'(nvm_write_en === 1'b1);
            nh += int'(high_voltage_off_flag === 1'b1);
            if (cpu_stall !== (prog | high_voltage_off_flag)) sbad++;
            if (data_read_block !== prog) sbad++;
            @(posedge mclk);
            #1;
        end
        if (k == 400) begin
            bad_count++;
            stop_test();
        end
        check(17'(sbad), 17'h0);
        check(17'(ne), er ? 17'(nvmwu_pkg::ERASE_CYCLES) : 17'h0);
        check(17'(nw), wr ? 17'(nvmwu_pkg::WRITE_CYCLES) : 17'h0);
        check(17'(nh), 17'(nvmwu_pkg::HV_CLOSE_CYCLES));
        check(17'(mem_irq), 17'(irq));
        status_is(st | ST_DONE);
        check(17'(mem_irq), 17'h0);
    endtask

    task automatic t_reset_refuse();
        do_reset();
        status_is(8'h00);
        reg_write(nvmwu_pkg::CTRL_ONE_OFS, 8'h02);
        mem_write(17'h08200, 8'h12, 1'b1);
        mem_write(17'h01000, 8'h12, 1'b1);
        @(posedge mclk);
        #1;
        check(17'(nvm_busy), 17'h0);
        check(17'(mem_irq), 17'h1);
        status_is(ST_WPA);
        check(17'(mem_irq), 17'h0);
    endtask

    task automatic t_prog_keys();
        do_reset();
        keys(nvmwu_pkg::PROG_KEY_OFS, 8'h55, 8'h56);
        reg_write(nvmwu_pkg::PROG_KEY_OFS, 8'hAE);
        status_is(8'h00);
        do_reset();
        keys(nvmwu_pkg::PROG_KEY_OFS, 8'h56, 8'hAD);
        keys(nvmwu_pkg::PROG_KEY_OFS, 8'h56, 8'hAE);
        status_is(8'h00);
        do_reset();
        keys(nvmwu_pkg::PROG_KEY_OFS, 8'h56, 8'hAE);
        status_is(ST_PROG);
        mem_write(17'h081FF, 8'h5A, 1'b1);
        status_is(ST_PROG | ST_WPA);
        run_op(17'h08200, 8'h5A, 1'b1, 1'b1, 1'b0, 1'b1, ST_PROG, 1'b0);
        reg_write(nvmwu_pkg::STATUS_OFS, 8'h00);
        mem_write(17'h08200, 8'h5A, 1'b1);
        status_is(ST_WPA);
    endtask

    task automatic t_data_ops();
        do_reset();
        reg_write(nvmwu_pkg::DATA_KEY_OFS, 8'h12);
        keys(nvmwu_pkg::DATA_KEY_OFS, 8'hAE, 8'h56);
        status_is(ST_DATA);
        run_op(17'h01010, 8'h33, 1'b0, 1'b0, 1'b1, 1'b1, ST_DATA, 1'b0);
        run_op(17'h01011, 8'h00, 1'b1, 1'b0, 1'b1, 1'b0, ST_DATA, 1'b0);
        // Fixed time and interrupt enable together
        reg_write(nvmwu_pkg::CTRL_ONE_OFS, 8'h03);
        run_op(17'h017FF, 8'h77, 1'b1, 1'b0, 1'b1, 1'b1, ST_DATA, 1'b1);
        reg_write(nvmwu_pkg::STATUS_OFS, 8'h00);
        status_is(8'h00);
        do_reset();
        keys(nvmwu_pkg::DATA_KEY_OFS, 8'hAE, 8'h55);
        keys(nvmwu_pkg::DATA_KEY_OFS, 8'hAE, 8'h56);
        status_is(8'h00);
    endtask

    task automatic t_option();
        do_reset();
        mem_write(17'h04810, 8'h11, 1'b1);
        status_is(ST_WPA);
        reg_write(nvmwu_pkg::CTRL_TWO_OFS, 8'h80);
        run_op(17'h04810, 8'h11, 1'b1, 1'b0, 1'b0, 1'b1, 8'h00, 1'b0);
    endtask

    initial begin
        t_reset_refuse();
        t_prog_keys();
        t_data_ops();
        t_option();
        stop_test();
    end
endmodule
